// ---- verilog/control_pin_function_logic.sv ----
// Reference select, shutdown/output-enable and config-select pin decoding
//
// Our own choices: the address-and-strobe port and the placing of the registers.
`timescale 1ns/1ps
`include "pin_ctrl_defs.svh"
module control_pin_function_logic (
  input  wire logic               mclk,                       // 100 MHz clock
  input  wire logic               resetn,                     // Async reset, active low
  input  wire logic               ref_source_select,          // Reference select pin
  input  wire logic               shutdown_or_out_enable_pin, // Dual-function control pin
  input  wire logic               cfg_select_hi,              // Config select high / serial data pin
  input  wire logic               cfg_select_lo,              // Config select low / serial clock pin
  input  wire pin_ctrl_pkg::addr_t addr,                      // Register address
  input  wire pin_ctrl_pkg::data_t wdata,                     // Register write data
  input  wire logic               wr,                         // Write strobe
  input  wire logic               rd,                         // Read strobe
  output pin_ctrl_pkg::data_t     rdata,                      // Read data, cycle after rd
  output logic                    ref_is_ext,                 // 1 external input, 0 crystal
  output logic                    chip_shutdown,              // Chip powered down
  output logic                    outs_disabled,              // Outputs disabled by pin
  output pin_ctrl_pkg::out_vec_t  out_drive_en,               // Per-output driver enable
  output pin_ctrl_pkg::out_vec_t  out_force,                  // Per-output clock replaced by level
  output pin_ctrl_pkg::out_vec_t  out_level,                  // Per-output forced level
  output logic [1:0]              cfg_sel,                    // Selected configuration
  output logic                    sda_in,                     // Serial data toward interface
  output logic                    scl_in                      // Serial clock toward interface
);
  import pin_ctrl_pkg::*;

  state_s    st_q;
  state_s    st_d;
  pin_vec_t  pins_s;
  pin_role_e role;
  logic      pin_active;

  pin_sync #(
    .W (`PIN_W)
  ) u_pin_sync (
    .mclk   (mclk),
    .resetn (resetn),
    .d      ({cfg_select_hi, cfg_select_lo, shutdown_or_out_enable_pin, ref_source_select}),
    .q      (pins_s)
  );

  assign role       = st_q.ctrl[`CTRL_ROLE] ? ROLE_SD : ROLE_OE;
  // Polarity bit high means the pin is asserted when high
  assign pin_active = (pins_s[`PIN_SDOE] == st_q.ctrl[`CTRL_POL]);

  always_comb begin
    st_d = st_q;

    // Register writes
    if (wr) begin
      case (addr)
        `OFS_CTRL: begin
          st_d.ctrl = wdata[`CTRL_W-1:0];
        end
        `OFS_DISCFG: begin
          st_d.discfg = wdata[2*`N_OUT-1:0];
        end
        default: begin
        end
      endcase
    end

    // Register reads; unmapped addresses read as zero
    st_d.rdata = '0;
    if (rd) begin
      case (addr)
        `OFS_CTRL: begin
          st_d.rdata[`CTRL_W-1:0] = st_q.ctrl;
        end
        `OFS_DISCFG: begin
          st_d.rdata[2*`N_OUT-1:0] = st_q.discfg;
        end
        `OFS_STATUS: begin
          st_d.rdata[`STAT_REF]                 = st_q.ref_is_ext;
          st_d.rdata[`STAT_SD]                  = st_q.shutdown;
          st_d.rdata[`STAT_DIS]                 = st_q.outs_off;
          st_d.rdata[`STAT_CFG_HI:`STAT_CFG_LO] = st_q.cfg_sel;
          st_d.rdata[`STAT_PIN_HI:`STAT_PIN_LO] = pins_s;
        end
        default: begin
        end
      endcase
    end

    // Reference choice follows the pin only in manual mode; else it holds
    if (st_q.ctrl[`CTRL_MANUAL]) begin
      st_d.ref_is_ext = pins_s[`PIN_REF] ^ st_q.ctrl[`CTRL_SEL_INV];
    end

    // Dual-function pin
    st_d.shutdown = (role == ROLE_SD) && pin_active;
    st_d.outs_off = (role == ROLE_OE) && pin_active;

    for (int i = 0; i < `N_OUT; i++) begin
      st_d.level[i] = st_q.discfg[2*i+`DIS_LEVEL];
      if (st_d.shutdown) begin
        // Shutdown never floats an output, it always drives the level
        st_d.drive_en[i]  = 1'b1;
        st_d.force_lvl[i] = 1'b1;
      end else if (st_d.outs_off) begin
        st_d.drive_en[i]  = ~st_q.discfg[2*i+`DIS_TRI];
        st_d.force_lvl[i] = 1'b1;
      end else begin
        st_d.drive_en[i]  = 1'b1;
        st_d.force_lvl[i] = 1'b0;
      end
    end

    // Pin pair role: config selectors, or serial lines idling high
    if (st_q.ctrl[`CTRL_SERIAL]) begin
      st_d.sda_in = pins_s[`PIN_SEL_HI];
      st_d.scl_in = pins_s[`PIN_SEL_LO];
    end else begin
      // Config levels are taken as they stand; a host that moves them mid-use gets a new config
      st_d.cfg_sel = {pins_s[`PIN_SEL_HI], pins_s[`PIN_SEL_LO]};
      st_d.sda_in  = 1'b1;
      st_d.scl_in  = 1'b1;
    end
  end

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      st_q            <= '0;
      st_q.ctrl       <= `CTRL_RST;
      st_q.discfg     <= `DISCFG_RST;
      st_q.drive_en   <= '1;
      st_q.sda_in     <= 1'b1;
      st_q.scl_in     <= 1'b1;
    end else begin
      st_q <= st_d;
    end
  end

  assign rdata         = st_q.rdata;
  assign ref_is_ext    = st_q.ref_is_ext;
  assign chip_shutdown = st_q.shutdown;
  assign outs_disabled = st_q.outs_off;
  assign out_drive_en  = st_q.drive_en;
  assign out_force     = st_q.force_lvl;
  assign out_level     = st_q.level;
  assign cfg_sel       = st_q.cfg_sel;
  assign sda_in        = st_q.sda_in;
  assign scl_in        = st_q.scl_in;

  // Per-output views of the disable configuration, used by the checks below
  out_vec_t cfg_lvl;
  out_vec_t cfg_tri;

  always_comb begin
    cfg_lvl = '0;
    cfg_tri = '0;
    for (int i = 0; i < `N_OUT; i++) begin
      cfg_lvl[i] = st_q.discfg[2*i+`DIS_LEVEL];
      cfg_tri[i] = st_q.discfg[2*i+`DIS_TRI];
    end
  end

  // Checks
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!resetn);

  a_ref_manual_follow: assert property (
    st_q.ctrl[`CTRL_MANUAL] |=> (ref_is_ext == $past(pins_s[`PIN_REF] ^ st_q.ctrl[`CTRL_SEL_INV])))
    else $error("reference choice does not follow select pin");

  a_ref_xtal_low: assert property (
    (st_q.ctrl[`CTRL_MANUAL] && !st_q.ctrl[`CTRL_SEL_INV] && !pins_s[`PIN_REF]) |=> !ref_is_ext)
    else $error("select low did not pick crystal");

  a_ref_hold_auto: assert property (
    !st_q.ctrl[`CTRL_MANUAL] |=> $stable(ref_is_ext))
    else $error("reference moved outside manual mode");

  a_sd_entry: assert property (
    (role == ROLE_SD && pin_active) |=> (chip_shutdown && !outs_disabled))
    else $error("shutdown not entered");

  a_oe_no_shutdown: assert property (
    (role == ROLE_OE) |=> !chip_shutdown)
    else $error("shutdown while pin in enable role");

  a_pol_inactive: assert property (
    (pins_s[`PIN_SDOE] != st_q.ctrl[`CTRL_POL]) |=> (!chip_shutdown && !outs_disabled))
    else $error("inactive pin level took effect");

  a_sd_levels: assert property (
    chip_shutdown |-> (&out_drive_en && &out_force))
    else $error("shutdown output not driven to level");

  a_dis_tristate: assert property (
    (outs_disabled && !$past(wr)) |-> (out_drive_en[0] == !$past(st_q.discfg[`DIS_TRI], 1) && out_force[0]))
    else $error("disabled output state wrong");

  a_serial_cfg_hold: assert property (
    st_q.ctrl[`CTRL_SERIAL] |=> ($stable(cfg_sel) && sda_in == $past(pins_s[`PIN_SEL_HI])))
    else $error("serial mode pin pair misrouted");

  a_cfg_idle_lines: assert property (
    !st_q.ctrl[`CTRL_SERIAL] |=> (sda_in && scl_in && cfg_sel == $past({pins_s[`PIN_SEL_HI], pins_s[`PIN_SEL_LO]})))
    else $error("config select mode misrouted");

  a_rd_ctrl: assert property (
    (rd && addr == `OFS_CTRL) |=> (rdata[`CTRL_W-1:0] == $past(st_q.ctrl) && rdata[`DATA_W-1:`CTRL_W] == '0))
    else $error("control read data wrong");

  // Output state checks
  a_sd_level_copy: assert property (
    chip_shutdown |-> (out_level == $past(cfg_lvl)))
    else $error("shutdown level not the programmed one");

  a_dis_level_copy: assert property (
    outs_disabled |-> (out_level == $past(cfg_lvl) && &out_force))
    else $error("disabled level not the programmed one");

  a_dis_drive_sel: assert property (
    outs_disabled |-> (out_drive_en == ~$past(cfg_tri)))
    else $error("disabled driver enables wrong");

  a_run_clocks_on: assert property (
    (!chip_shutdown && !outs_disabled) |-> (&out_drive_en && out_force == '0))
    else $error("outputs not running while pin inactive");

  a_shutdown_or_out_enable_pin_exclusive: assert property (
    !(chip_shutdown && outs_disabled))
    else $error("shutdown and disable both set");

  a_oe_entry: assert property (
    (role == ROLE_OE && pin_active) |=> (outs_disabled && !chip_shutdown))
    else $error("output disable not entered");

  a_sd_no_disable: assert property (
    (role == ROLE_SD) |=> !outs_disabled)
    else $error("disable while pin in shutdown role");

  a_pol_high_on: assert property (
    (st_q.ctrl[`CTRL_POL] && pins_s[`PIN_SDOE]) |=> (chip_shutdown || outs_disabled))
    else $error("active high pin ignored");

  a_pol_low_on: assert property (
    (!st_q.ctrl[`CTRL_POL] && !pins_s[`PIN_SDOE]) |=> (chip_shutdown || outs_disabled))
    else $error("active low pin ignored");

  a_sd_active_low: assert property (
    (st_q.ctrl[`CTRL_ROLE] && !st_q.ctrl[`CTRL_POL] && !pins_s[`PIN_SDOE]) |=> chip_shutdown)
    else $error("active low shutdown not entered");

  a_ref_ext_high: assert property (
    (st_q.ctrl[`CTRL_MANUAL] && !st_q.ctrl[`CTRL_SEL_INV] && pins_s[`PIN_REF]) |=> ref_is_ext)
    else $error("select high did not pick external input");

  a_ref_inverted: assert property (
    (st_q.ctrl[`CTRL_MANUAL] && st_q.ctrl[`CTRL_SEL_INV]) |=> (ref_is_ext != $past(pins_s[`PIN_REF])))
    else $error("inverted select sense not applied");

  a_serial_clk_route: assert property (
    st_q.ctrl[`CTRL_SERIAL] |=> (scl_in == $past(pins_s[`PIN_SEL_LO])))
    else $error("serial clock line misrouted");

  a_tri_only_disabled: assert property (
    (out_drive_en != '1) |-> outs_disabled)
    else $error("driver off outside output disable");

  a_force_only_off: assert property (
    (out_force != '0) |-> (chip_shutdown || outs_disabled))
    else $error("output level forced while running");

  // Register bus checks
  a_rd_idle_zero: assert property (
    !rd |=> (rdata == '0))
    else $error("read data not zero outside read");

  a_rd_discfg: assert property (
    (rd && addr == `OFS_DISCFG) |=> (rdata[2*`N_OUT-1:0] == $past(st_q.discfg) && rdata[`DATA_W-1:2*`N_OUT] == '0))
    else $error("disable config read data wrong");

  a_rd_status: assert property (
    (rd && addr == `OFS_STATUS) |=>
      (rdata[`STAT_REF] == $past(ref_is_ext) && rdata[`STAT_SD] == $past(chip_shutdown)
       && rdata[`STAT_DIS] == $past(outs_disabled) && rdata[`STAT_CFG_HI:`STAT_CFG_LO] == $past(cfg_sel)
       && rdata[`STAT_PIN_HI:`STAT_PIN_LO] == $past(pins_s) && rdata[`DATA_W-1:`STAT_PIN_HI+1] == '0))
    else $error("status read data wrong");

  a_rd_unmapped: assert property (
    (rd && addr != `OFS_CTRL && addr != `OFS_DISCFG && addr != `OFS_STATUS) |=> (rdata == '0))
    else $error("unmapped read not zero");

  a_wr_ctrl_lands: assert property (
    (wr && addr == `OFS_CTRL) |=> (st_q.ctrl == $past(wdata[`CTRL_W-1:0])))
    else $error("control write lost");

  a_wr_discfg_lands: assert property (
    (wr && addr == `OFS_DISCFG) |=> (st_q.discfg == $past(wdata[2*`N_OUT-1:0])))
    else $error("disable config write lost");

  a_wr_other_ignored: assert property (
    (wr && addr != `OFS_CTRL && addr != `OFS_DISCFG) |=> ($stable(st_q.ctrl) && $stable(st_q.discfg)))
    else $error("write to read-only or unmapped address took effect");

  c_oe_active_low: cover property (!st_q.ctrl[`CTRL_POL] && outs_disabled);
  c_shutdown: cover property (role == ROLE_SD ##1 pin_active ##1 chip_shutdown);
  c_disable_tri: cover property (outs_disabled && !out_drive_en[0]);
  c_ref_switch: cover property (!ref_is_ext ##[1:20] ref_is_ext);
  c_serial_mode: cover property (st_q.ctrl[`CTRL_SERIAL] && !sda_in);
endmodule // control_pin_function_logic

// ---- verilog/pin_ctrl_defs.svh ----
// Constants for the control pin decoding block
`ifndef PIN_CTRL_DEFS_SVH
`define PIN_CTRL_DEFS_SVH

`define N_OUT        5
`define ADDR_W       4
`define DATA_W       32

`define OFS_CTRL     4'h0
`define OFS_DISCFG   4'h4
`define OFS_STATUS   4'h8

// Control register fields
`define CTRL_SEL_INV 0
`define CTRL_ROLE    1
`define CTRL_POL     2
`define CTRL_SERIAL  3
`define CTRL_MANUAL  4
`define CTRL_W       5
`define CTRL_RST     5'h0_014

// Status register fields
`define STAT_REF     0
`define STAT_SD      1
`define STAT_DIS     2
`define STAT_CFG_LO  3
`define STAT_CFG_HI  4
`define STAT_PIN_LO  5
`define STAT_PIN_HI  8

// Disable configuration: two bits per output, [2i]=level, [2i+1]=high impedance
`define DIS_LEVEL    0
`define DIS_TRI      1
`define DISCFG_RST   10'h0_2aa

// Synchronised pin vector positions
`define PIN_REF      0
`define PIN_SDOE     1
`define PIN_SEL_LO   2
`define PIN_SEL_HI   3
`define PIN_W        4

`endif

// ---- verilog/pin_ctrl_pkg.sv ----
// Types shared by the control pin decoding block
`include "pin_ctrl_defs.svh"
package pin_ctrl_pkg;
  typedef logic [`N_OUT-1:0]   out_vec_t;
  typedef logic [2*`N_OUT-1:0] discfg_t;
  typedef logic [`ADDR_W-1:0]  addr_t;
  typedef logic [`DATA_W-1:0]  data_t;
  typedef logic [`PIN_W-1:0]   pin_vec_t;

  typedef enum logic {ROLE_OE, ROLE_SD} pin_role_e;

  typedef struct packed {
    logic [`CTRL_W-1:0] ctrl;
    discfg_t            discfg;
    data_t              rdata;
    logic               ref_is_ext;
    logic               shutdown;
    logic               outs_off;
    out_vec_t           drive_en;
    out_vec_t           force_lvl;
    out_vec_t           level;
    logic [1:0]         cfg_sel;
    logic               sda_in;
    logic               scl_in;
  } state_s;
endpackage

// ---- verilog/pin_sync.sv ----
// Two-flop synchroniser for asynchronous pin levels
`timescale 1ns/1ps
module pin_sync #(
  parameter int W = 1
) (
  input  wire logic         mclk,    // System clock
  input  wire logic         resetn,  // Async reset, active low
  input  wire logic [W-1:0] d,       // Asynchronous levels
  output logic      [W-1:0] q        // Synchronised levels
);
  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
  } sync_s;

  sync_s st_q;
  sync_s st_d;

  always_comb begin
    st_d    = st_q;
    st_d.s1 = d;
    st_d.s2 = st_q.s1;
  end

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  assign q = st_q.s2;
endmodule // pin_sync

// ---- dv/pin_host_model.sv ----
// Board-side model that drives the four control pins
`timescale 1ns/1ps
module pin_host_model (
  input  wire logic                 mclk,  // Board clock
  input  wire pin_ctrl_pkg::pin_vec_t want, // Requested pin levels
  output pin_ctrl_pkg::pin_vec_t      pins   // Pin levels seen by the device
);
  import pin_ctrl_pkg::*;
  // Levels change only on request and then stand, so samples stay stable
  always_ff @(posedge mclk) begin
    pins <= want;
  end
endmodule // pin_host_model

// ---- dv/control_pin_function_logic_tb.sv ----
// Self-checking bench for the control pin decoding block
`timescale 1ns/1ps
module control_pin_function_logic_tb;
  import pin_ctrl_pkg::*;
  localparam logic [21:0] M_EXT = 22'h20_0000;
  localparam logic [21:0] M_SD  = 22'h10_0000;
  localparam logic [21:0] M_DIS = 22'h08_0000;
  localparam logic [21:0] M_EN  = 22'h07_c000;
  localparam logic [21:0] M_FRC = 22'h00_3e00;
  localparam logic [21:0] M_LVL = 22'h00_01f0;
  localparam logic [21:0] M_SEL = 22'h00_000f;
  logic        mclk = 1'b0;
  logic        resetn = 1'b0;
  pin_vec_t    want = '0;
  pin_vec_t    pins;
  addr_t       addr = '0;
  data_t       wdata = '0;
  logic        wr = 1'b0;
  logic        rd = 1'b0;
  data_t       rdata;
  logic        ext, sd, dis, sda, scl;
  out_vec_t    en, frc, lvl;
  logic [1:0]  sel;
  int          mismatches = 0;
  int          n_checks = 0;
  always #5 mclk = ~mclk;
  pin_host_model i_host (.mclk(mclk), .want(want), .pins(pins));
  control_pin_function_logic i_dut (.mclk(mclk), .resetn(resetn), .ref_source_select(pins[0]),
    .shutdown_or_out_enable_pin(pins[1]), .cfg_select_lo(pins[2]), .cfg_select_hi(pins[3]),
    .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .ref_is_ext(ext),
    .chip_shutdown(sd), .outs_disabled(dis), .out_drive_en(en), .out_force(frc),
    .out_level(lvl), .cfg_sel(sel), .sda_in(sda), .scl_in(scl));
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic wr_reg(input addr_t a, input data_t d);
    @(posedge mclk);
    wr <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge mclk);
    wr <= 1'b0;
  endtask
  task automatic rd_chk(input addr_t a, input data_t exp);
    @(posedge mclk);
    rd <= 1'b1;
    addr <= a;
    @(posedge mclk);
    rd <= 1'b0;
    #1;
    n_checks++;
    if (rdata !== exp) begin
      mismatches++;
      $display("BAD %0t read %h got %h", $time, a, rdata);
    end
  endtask
  // Model flop plus two sync flops plus output flop, with margin
  task automatic pin_set(input pin_vec_t p);
    @(posedge mclk);
    want <= p;
    repeat (6) @(posedge mclk);
    #1;
  endtask
  task automatic chk_out(input logic [21:0] exp, input logic [21:0] m);
    n_checks++;
    if (({ext, sd, dis, en, frc, lvl, sel, sda, scl} & m) !== (exp & m)) begin
      mismatches++;
      $display("BAD %0t outputs %h", $time, {ext, sd, dis, en, frc, lvl, sel, sda, scl});
    end
  endtask
  initial begin
    repeat (3000) @(posedge mclk);
    mismatches++;
    tally_and_finish();
  end
  initial begin
    repeat (12) @(posedge mclk);
    resetn <= 1'b1;
    rd_chk(4'h0, 32'h0000_0014);
    rd_chk(4'h4, 32'h0000_02aa);
    rd_chk(4'hc, 32'h0000_0000);
    wr_reg(4'h8, 32'hffff_ffff);
    rd_chk(4'h0, 32'h0000_0014);
    rd_chk(4'h4, 32'h0000_02aa);
    chk_out(22'h07_c003, 22'h3f_ffff);
    $display("test reset done");
    pin_set(4'h1);
    chk_out(M_EXT, M_EXT);
    rd_chk(4'h8, 32'h0000_0021);
    pin_set(4'h0);
    chk_out(22'h00_0000, M_EXT);
    wr_reg(4'h0, 32'h0000_0015);
    pin_set(4'h0);
    chk_out(M_EXT, M_EXT);
    wr_reg(4'h0, 32'h0000_0005);
    pin_set(4'h1);
    chk_out(M_EXT, M_EXT);
    $display("test reference done");
    wr_reg(4'h0, 32'h0000_0016);
    wr_reg(4'h4, 32'h0000_0155);
    pin_set(4'h2);
    chk_out(22'h17_fff0, M_SD | M_DIS | M_EN | M_FRC | M_LVL);
    pin_set(4'h0);
    chk_out(22'h07_c000, M_SD | M_FRC);
    $display("test shutdown done");
    wr_reg(4'h0, 32'h0000_0014);
    wr_reg(4'h4, 32'h0000_02aa);
    pin_set(4'h2);
    chk_out(M_DIS, M_SD | M_DIS | M_EN);
    wr_reg(4'h4, 32'h0000_0001);
    pin_set(4'h2);
    chk_out(22'h0f_fe10, M_DIS | M_EN | M_FRC | M_LVL);
    wr_reg(4'h0, 32'h0000_0010);
    pin_set(4'h2);
    chk_out(22'h07_c000, M_DIS | M_EN | M_FRC);
    pin_set(4'h0);
    chk_out(M_DIS, M_DIS);
    wr_reg(4'h0, 32'h0000_0012);
    pin_set(4'h0);
    chk_out(22'h17_fe10, M_SD | M_DIS | M_EN | M_FRC | M_LVL);
    $display("test enable done");
    wr_reg(4'h0, 32'h0000_0014);
    pin_set(4'h8);
    chk_out(22'h00_000b, M_SEL);
    wr_reg(4'h0, 32'h0000_001c);
    pin_set(4'h4);
    chk_out(22'h00_0009, M_SEL);
    $display("test select done");
    @(posedge mclk);
    resetn <= 1'b0;
    repeat (3) @(posedge mclk);
    resetn <= 1'b1;
    rd_chk(4'h0, 32'h0000_0014);
    rd_chk(4'h4, 32'h0000_02aa);
    pin_set(4'h4);
    chk_out(22'h07_c007, 22'h3f_ffff);
    $display("test reset again done");
    tally_and_finish();
  end
endmodule // control_pin_function_logic_tb
